// [core/wdog_pkg.sv]
// constants, carriers and state type of the crash watchdog
package wdog_pkg;
  localparam logic [31:0] WDG_BASE_ADDR = 32'h4070_0000;
  localparam logic [11:0] OFF_RELOAD = 12'h000;
  localparam logic [11:0] OFF_COUNT = 12'h004;
  localparam logic [11:0] OFF_CTRL = 12'h008;
  localparam logic [11:0] OFF_ACK = 12'h00c;
  localparam logic [11:0] OFF_RAW = 12'h010;
  localparam logic [11:0] OFF_MASKED = 12'h014;
  localparam logic [11:0] OFF_PROTECT = 12'hc00;
  localparam logic [31:0] RELOAD_RST = 32'h0fff_ffff;
  localparam logic [31:0] COUNT_RST = 32'h0fff_ffff;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int CTRL_IRQ_EN_BIT = 0;
  localparam int CTRL_RST_EN_BIT = 1;
  localparam logic RAW_RST = 1'b0;
  localparam logic LOCKED_RST = 1'b0;
  localparam logic [31:0] PROTECT_KEY = 32'h1acc_e551;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RST_PULSE_NS = 1000;
  localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    REG_NONE, REG_RELOAD, REG_COUNT, REG_CTRL, REG_ACK, REG_RAW, REG_MASKED, REG_PROTECT
  } reg_sel_t;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic sync3;
    logic [31:0] reload;
    logic [31:0] count;
    logic irq_en;
    logic rst_en;
    logic raw;
    logic locked;
    logic [7:0] rst_cnt;
    logic rst_out;
    logic irq_out;
    logic aw_hold;
    logic [31:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    axil_rsp_t bus;
  } wd_state_t;
endpackage

// [core/software_crash_watchdog.sv]
// crash watchdog: slow-tick down counter, reset on unserved expiry, axi4-lite registers
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - 32-bit counter decrements per slow tick
// - interrupt period is load value plus one
// - zero while enabled sets interrupt status
// - reload from load register, keep counting
// - second expiry with status set resets system
// - disable stops; enable restarts from load value
// - key write unlocks other register writes
// - other value locks; blocked writes change nothing
// - registers decoded at fixed peripheral base
// - load write restarts count immediately
// - count register reads live count, ignores writes
// - control bit 0 enables interrupts, resets 0
// - control bit 1 enables reset, resets 0
// - acknowledge write clears status, reloads; reads zero
// - load and count reset 0x0fffffff, others zero
// - raw and masked status read-only bit 0
// - protect register reads 1 when locked
module software_crash_watchdog
  import wdog_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_slow_clk,
  input wire axil_req_t i_axi,
  output var axil_rsp_t o_axi,
  output logic o_wdt_irq,
  output logic o_wdt_reset
);

  wd_state_t s;
  wd_state_t next_s;
  logic slow_tick;
  logic expire;
  reg_sel_t wr_sel;
  reg_sel_t rd_sel;
  logic wr_exec;
  logic wr_ok;
  logic [31:0] wr_word;
  logic [31:0] prot_word;

  function automatic reg_sel_t decode(input logic [31:0] addr);
    reg_sel_t sel;
    sel = REG_NONE;
    if (addr[31:12] == WDG_BASE_ADDR[31:12])
    begin
      case (addr[11:0])
        OFF_RELOAD: sel = REG_RELOAD;
        OFF_COUNT: sel = REG_COUNT;
        OFF_CTRL: sel = REG_CTRL;
        OFF_ACK: sel = REG_ACK;
        OFF_RAW: sel = REG_RAW;
        OFF_MASKED: sel = REG_MASKED;
        OFF_PROTECT: sel = REG_PROTECT;
        default: sel = REG_NONE;
      endcase
    end
    return sel;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // slow clock edge after two-flop synchroniser
  assign slow_tick = s.sync2 & ~s.sync3;
  assign expire = slow_tick & s.irq_en & (s.count == 32'h0);
  assign wr_sel = decode(s.aw_addr);
  assign rd_sel = decode(i_axi.araddr);
  assign wr_exec = s.aw_hold & s.w_hold & ~s.bus.bvalid;
  assign wr_ok = wr_exec & ((wr_sel == REG_PROTECT) | (~s.locked & (wr_sel != REG_NONE)));
  assign wr_word = merge(s.reload, s.w_data, s.w_strb);
  assign prot_word = merge(32'h0, s.w_data, s.w_strb);

  always_comb
  begin
    next_s = s;
    next_s.sync1 = i_slow_clk;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    if (slow_tick && s.irq_en)
    begin
      if (s.count == 32'h0)
      begin
        next_s.raw = 1'b1;
        next_s.count = s.reload;
      end
      else
      begin
        next_s.count = s.count - 32'h1;
      end
    end
    if (s.rst_cnt != 8'h0)
    begin
      next_s.rst_cnt = s.rst_cnt - 8'h1;
    end
    if (expire && s.raw && s.rst_en)
    begin
      next_s.rst_cnt = RST_PULSE_CYC[7:0];
    end
    // write channel capture
    if (i_axi.awvalid && s.bus.awready)
    begin
      next_s.aw_hold = 1'b1;
      next_s.aw_addr = i_axi.awaddr;
    end
    if (i_axi.wvalid && s.bus.wready)
    begin
      next_s.w_hold = 1'b1;
      next_s.w_data = i_axi.wdata;
      next_s.w_strb = i_axi.wstrb;
    end
    if (s.bus.bvalid && i_axi.bready)
    begin
      next_s.bus.bvalid = 1'b0;
    end
    if (wr_exec)
    begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold = 1'b0;
      next_s.bus.bvalid = 1'b1;
      next_s.bus.bresp = (wr_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
    end
    if (wr_ok)
    begin
      case (wr_sel)
        REG_RELOAD:
        begin
          next_s.reload = wr_word;
          next_s.count = wr_word;
        end
        REG_CTRL:
        begin
          next_s.irq_en = (s.w_strb[0]) ? s.w_data[CTRL_IRQ_EN_BIT] : s.irq_en;
          next_s.rst_en = (s.w_strb[0]) ? s.w_data[CTRL_RST_EN_BIT] : s.rst_en;
        end
        REG_ACK:
        begin
          // an expiry in the same cycle wins over the clear
          next_s.raw = expire;
          next_s.count = s.reload;
        end
        REG_PROTECT: next_s.locked = (prot_word != PROTECT_KEY);
        default: next_s.locked = s.locked;
      endcase
    end
    if (!s.irq_en && next_s.irq_en)
    begin
      next_s.count = next_s.reload;
    end
    if (!next_s.rst_en)
    begin
      next_s.rst_cnt = 8'h0;
    end
    next_s.rst_out = (next_s.rst_cnt != 8'h0);
    next_s.irq_out = next_s.raw & next_s.irq_en;
    next_s.bus.awready = ~next_s.aw_hold & ~next_s.bus.bvalid;
    next_s.bus.wready = ~next_s.w_hold & ~next_s.bus.bvalid;
    // read channel
    if (s.bus.rvalid && i_axi.rready)
    begin
      next_s.bus.rvalid = 1'b0;
    end
    if (i_axi.arvalid && s.bus.arready)
    begin
      next_s.bus.rvalid = 1'b1;
      next_s.bus.rresp = (rd_sel == REG_NONE) ? RESP_DECERR : RESP_OKAY;
      case (rd_sel)
        REG_RELOAD: next_s.bus.rdata = s.reload;
        REG_COUNT: next_s.bus.rdata = s.count;
        REG_CTRL: next_s.bus.rdata = {30'h0, s.rst_en, s.irq_en};
        REG_RAW: next_s.bus.rdata = {31'h0, s.raw};
        REG_MASKED: next_s.bus.rdata = {31'h0, s.raw & s.irq_en};
        REG_PROTECT: next_s.bus.rdata = {31'h0, s.locked};
        default: next_s.bus.rdata = 32'h0;
      endcase
    end
    next_s.bus.arready = ~next_s.bus.rvalid;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      s <= '0;
      s.reload <= RELOAD_RST;
      s.count <= COUNT_RST;
      s.irq_en <= CTRL_RST[CTRL_IRQ_EN_BIT];
      s.rst_en <= CTRL_RST[CTRL_RST_EN_BIT];
      s.raw <= RAW_RST;
      s.locked <= LOCKED_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_axi = s.bus;
  assign o_wdt_irq = s.irq_out;
  assign o_wdt_reset = s.rst_out;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);

  sequence seq_expire;
    slow_tick && s.irq_en && (s.count == 32'h0) && !wr_ok;
  endsequence

  sequence seq_rd(reg_sel_t sel);
    i_axi.arvalid && s.bus.arready && (rd_sel == sel);
  endsequence

  property p_count_dec;
    slow_tick && s.irq_en && (s.count != 32'h0) && !wr_ok |=> s.count == $past(s.count) - 32'h1;
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count did not decrement");

  property p_zero_irq;
    seq_expire |=> s.raw;
  endproperty
  a_zero_irq: assert property (p_zero_irq) else $error("expiry did not set status");

  property p_reload;
    seq_expire |=> s.count == $past(s.reload);
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");

  property p_reset_fire;
    seq_expire ##0 (s.raw && s.rst_en) |=> o_wdt_reset;
  endproperty
  a_reset_fire: assert property (p_reset_fire) else $error("no reset on second expiry");

  property p_stop;
    !s.irq_en && !wr_ok |=> s.count == $past(s.count);
  endproperty
  a_stop: assert property (p_stop) else $error("counter ran while disabled");

  property p_restart;
    !s.irq_en ##1 s.irq_en |-> s.count == s.reload;
  endproperty
  a_restart: assert property (p_restart) else $error("enable did not restart from load");

  property p_unlock;
    wr_exec && (wr_sel == REG_PROTECT) |=> s.locked == ($past(prot_word) != PROTECT_KEY);
  endproperty
  a_unlock: assert property (p_unlock) else $error("protect state wrong after write");

  property p_locked_hold;
    wr_exec && s.locked && (wr_sel != REG_PROTECT)
      |=> (s.reload == $past(s.reload)) && (s.irq_en == $past(s.irq_en));
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("write passed while locked");

  property p_load_wr;
    wr_ok && (wr_sel == REG_RELOAD) && (s.w_strb == 4'hf)
      |=> (s.count == $past(s.w_data)) && (s.reload == $past(s.w_data));
  endproperty
  a_load_wr: assert property (p_load_wr) else $error("load write did not restart");

  property p_ack_clr;
    wr_ok && (wr_sel == REG_ACK) && !expire |=> !s.raw ##1 !o_wdt_irq;
  endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("acknowledge did not clear");

  property p_ack_rd;
    seq_rd(REG_ACK) |=> s.bus.rvalid && (s.bus.rdata == 32'h0);
  endproperty
  a_ack_rd: assert property (p_ack_rd) else $error("acknowledge read not zero");

  property p_masked_rd;
    seq_rd(REG_MASKED) |=> s.bus.rdata[0] == $past(s.raw && s.irq_en);
  endproperty
  a_masked_rd: assert property (p_masked_rd) else $error("masked status wrong");

  property p_lock_rd;
    seq_rd(REG_PROTECT) |=> s.bus.rdata == {31'h0, $past(s.locked)};
  endproperty
  a_lock_rd: assert property (p_lock_rd) else $error("protect read wrong");

  property p_tick_sync;
    $rose(i_slow_clk) ##1 i_slow_clk [*2] |-> slow_tick;
  endproperty
  a_tick_sync: assert property (p_tick_sync) else $error("slow edge not seen");

  property p_pulse_len;
    $rose(o_wdt_reset) |-> (o_wdt_reset || !s.rst_en) [*8];
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too short");

  property p_pulse_gate;
    !s.rst_en |=> !o_wdt_reset;
  endproperty
  a_pulse_gate: assert property (p_pulse_gate) else $error("reset while disabled");

  property p_irq_follow;
    o_wdt_irq == (s.raw && s.irq_en);
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("interrupt output wrong");

  property p_count_rd;
    seq_rd(REG_COUNT) |=> s.bus.rdata == $past(s.count);
  endproperty
  a_count_rd: assert property (p_count_rd) else $error("count read not live");

  property p_raw_rd;
    seq_rd(REG_RAW) |=> s.bus.rdata == {31'h0, $past(s.raw)};
  endproperty
  a_raw_rd: assert property (p_raw_rd) else $error("raw status read wrong");

  property p_ctrl_rd;
    seq_rd(REG_CTRL) |=> s.bus.rdata == {30'h0, $past(s.rst_en), $past(s.irq_en)};
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control read wrong");

  property p_count_wr;
    wr_ok && (wr_sel == REG_COUNT) && !slow_tick |=> s.count == $past(s.count);
  endproperty
  a_count_wr: assert property (p_count_wr) else $error("count write took effect");

  property p_ack_reload;
    wr_ok && (wr_sel == REG_ACK) |=> s.count == $past(s.reload);
  endproperty
  a_ack_reload: assert property (p_ack_reload) else $error("acknowledge did not reload");

  property p_raw_hold;
    s.raw && !(wr_ok && (wr_sel == REG_ACK)) |=> s.raw;
  endproperty
  a_raw_hold: assert property (p_raw_hold) else $error("status dropped without clear");

  property p_ctrl_wr;
    wr_ok && (wr_sel == REG_CTRL) && s.w_strb[0]
      |=> (s.irq_en == $past(s.w_data[CTRL_IRQ_EN_BIT]))
          && (s.rst_en == $past(s.w_data[CTRL_RST_EN_BIT]));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write not applied");

  property p_no_fire;
    seq_expire ##0 !s.rst_en |=> !o_wdt_reset;
  endproperty
  a_no_fire: assert property (p_no_fire) else $error("reset with output disabled");

  property p_first_quiet;
    seq_expire ##0 (!s.raw && !o_wdt_reset) |=> !o_wdt_reset;
  endproperty
  a_first_quiet: assert property (p_first_quiet) else $error("reset on first expiry");

  property p_lock_block;
    s.locked && wr_exec && (wr_sel == REG_ACK) && !expire |=> s.raw == $past(s.raw);
  endproperty
  a_lock_block: assert property (p_lock_block) else $error("clear passed while locked");

  property p_decerr_wr;
    wr_exec && (wr_sel == REG_NONE) |=> s.bus.bvalid && (s.bus.bresp == RESP_DECERR);
  endproperty
  a_decerr_wr: assert property (p_decerr_wr) else $error("unmapped write not refused");

  property p_decerr_rd;
    seq_rd(REG_NONE) |=> (s.bus.rresp == RESP_DECERR) && (s.bus.rdata == 32'h0);
  endproperty
  a_decerr_rd: assert property (p_decerr_rd) else $error("unmapped read not refused");

endmodule
`default_nettype wire

// [test/wdog_far_side.sv]
// far side model: slow clock source and system reset capture
`timescale 1ns/1ns
`default_nettype none
module wdog_far_side
  import wdog_pkg::*;
#(
  parameter int HALF_CYC = 4
)
(
  input wire logic i_ref_clk,
  input wire logic i_sys_rst_req,
  output logic o_slow_clk,
  output logic [7:0] o_pulses,
  output logic [7:0] o_width
);
  logic [7:0] run;

  initial
  begin
    o_slow_clk = 1'b0;
    o_pulses = 8'h00;
    o_width = 8'h00;
    run = 8'h00;
  end

  // slow clock stands low between requested ticks
  task automatic tick(input int n, input int half = HALF_CYC);
    repeat (n)
    begin
      @(posedge i_ref_clk);
      o_slow_clk <= 1'b1;
      repeat (half) @(posedge i_ref_clk);
      o_slow_clk <= 1'b0;
      repeat (half) @(posedge i_ref_clk);
    end
  endtask

  // reset controller: count pulses and width of the last one
  always @(posedge i_ref_clk)
  begin
    if (i_sys_rst_req)
      run <= run + 8'h01;
    else if (run != 8'h00)
    begin
      o_width <= run;
      o_pulses <= o_pulses + 8'h01;
      run <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// [test/tb_software_crash_watchdog.sv]
// self-checking bench for the crash watchdog over axi4-lite
`timescale 1ns/1ns
`default_nettype none
module tb_software_crash_watchdog
  import wdog_pkg::*;
;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic slow_clk;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic irq;
  logic sys_rst;
  logic [7:0] pulses;
  logic [7:0] width;
  int fails = 0;
  int n_compared = 0;
  logic [11:0] offs [8] = '{OFF_RELOAD, OFF_COUNT, OFF_CTRL, OFF_ACK, OFF_RAW, OFF_MASKED,
                            OFF_PROTECT, 12'h018};
  logic [31:0] rst_vals [8] = '{RELOAD_RST, COUNT_RST, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  always #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;

  software_crash_watchdog uut (.i_ref_clk(ref_clk), .i_srst(srst), .i_slow_clk(slow_clk),
    .i_axi(req), .o_axi(rsp), .o_wdt_irq(irq), .o_wdt_reset(sys_rst));
  wdog_far_side far (.i_ref_clk(ref_clk), .i_sys_rst_req(sys_rst), .o_slow_clk(slow_clk),
    .o_pulses(pulses), .o_width(width));

  task automatic close_out;
    if (fails == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [11:0] off, input logic [31:0] d,
                     input logic [1:0] er = RESP_OKAY, input logic [3:0] st = 4'hf,
                     input logic [31:0] base = WDG_BASE_ADDR);
    int n;
    logic a;
    logic w;
    logic b;
    logic [1:0] rs;
    @(posedge ref_clk);
    req.awvalid <= 1'b1;
    req.awaddr <= base | {20'h0, off};
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= st;
    req.bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge ref_clk);
      a = req.awvalid && rsp.awready;
      w = req.wvalid && rsp.wready;
      b = rsp.bvalid;
      rs = rsp.bresp;
      @(posedge ref_clk);
      if (a)
        req.awvalid <= 1'b0;
      if (w)
        req.wvalid <= 1'b0;
      if (b)
      begin
        req.bready <= 1'b0;
        break;
      end
    end
    if (n == 50)
    begin
      fails++;
      close_out();
    end
    cmp({30'h0, rs}, {30'h0, er});
  endtask

  task automatic axr(input logic [11:0] off, input logic [31:0] exp,
                     input logic [1:0] er = RESP_OKAY, input logic [31:0] base = WDG_BASE_ADDR);
    int n;
    logic a;
    logic r;
    logic [31:0] rd;
    logic [1:0] rs;
    @(posedge ref_clk);
    req.arvalid <= 1'b1;
    req.araddr <= base | {20'h0, off};
    req.rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge ref_clk);
      a = req.arvalid && rsp.arready;
      r = rsp.rvalid;
      rd = rsp.rdata;
      rs = rsp.rresp;
      @(posedge ref_clk);
      if (a)
        req.arvalid <= 1'b0;
      if (r)
      begin
        req.rready <= 1'b0;
        break;
      end
    end
    if (n == 50)
    begin
      fails++;
      close_out();
    end
    cmp(rd, exp);
    cmp({30'h0, rs}, {30'h0, er});
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      axr(offs[i], rst_vals[i], (i == 7) ? RESP_DECERR : RESP_OKAY);
    end
    axw(OFF_RELOAD, 32'h0000_0001, RESP_DECERR, 4'hf, 32'h4060_0000);
    axr(OFF_RELOAD, 32'h0, RESP_DECERR, 32'h4060_0000);
    axr(12'h002, 32'h0, RESP_DECERR);
    axw(OFF_RELOAD, 32'h1234_5678, RESP_OKAY, 4'h3);
    axr(OFF_RELOAD, 32'h0fff_5678);
    axr(OFF_COUNT, 32'h0fff_5678);
    axw(OFF_RELOAD, 32'h0000_0005);
    axr(OFF_COUNT, 32'h0000_0005);
    axw(OFF_COUNT, 32'h0000_0077);
    axr(OFF_COUNT, 32'h0000_0005);
    axw(12'h018, 32'h0000_0001, RESP_DECERR);
    axw(OFF_RAW, 32'h0000_0001);
    axr(OFF_RAW, 32'h0);
    axw(OFF_PROTECT, 32'h0);
    axr(OFF_PROTECT, 32'h0000_0001);
    axw(OFF_RELOAD, 32'h0000_0009);
    axw(OFF_ACK, 32'h0000_0001);
    axw(OFF_CTRL, 32'h0000_0003);
    axr(OFF_RELOAD, 32'h0000_0005);
    axr(OFF_CTRL, 32'h0);
    axw(OFF_PROTECT, PROTECT_KEY);
    axr(OFF_PROTECT, 32'h0);
    axw(OFF_PROTECT, PROTECT_KEY, RESP_OKAY, 4'h7);
    axr(OFF_PROTECT, 32'h0000_0001);
    axw(OFF_PROTECT, PROTECT_KEY);
    axw(OFF_CTRL, 32'h0000_0003, RESP_OKAY, 4'he);
    axr(OFF_CTRL, 32'h0);
    axw(OFF_CTRL, 32'h0000_0001);
    far.tick(5);
    axr(OFF_COUNT, 32'h0);
    axr(OFF_RAW, 32'h0);
    far.tick(1);
    axr(OFF_RAW, 32'h0000_0001);
    axr(OFF_COUNT, 32'h0000_0005);
    axr(OFF_MASKED, 32'h0000_0001);
    cmp({31'h0, irq}, 32'h0000_0001);
    far.tick(2, 3);
    axw(OFF_CTRL, 32'h0);
    axr(OFF_MASKED, 32'h0);
    cmp({31'h0, irq}, 32'h0);
    far.tick(2);
    axr(OFF_COUNT, 32'h0000_0003);
    axw(OFF_CTRL, 32'h0000_0001);
    axr(OFF_COUNT, 32'h0000_0005);
    far.tick(2);
    axw(OFF_ACK, 32'h1234_abcd);
    axr(OFF_RAW, 32'h0);
    axr(OFF_COUNT, 32'h0000_0005);
    axw(OFF_CTRL, 32'h0000_0003);
    far.tick(6);
    repeat (30) @(posedge ref_clk);
    cmp({24'h0, pulses}, 32'h0);
    far.tick(6);
    repeat (30) @(posedge ref_clk);
    cmp({24'h0, pulses}, 32'h0000_0001);
    cmp({24'h0, width}, RST_PULSE_CYC);
    axw(OFF_CTRL, 32'h0000_0001);
    axr(OFF_CTRL, 32'h0000_0001);
    far.tick(6);
    repeat (30) @(posedge ref_clk);
    cmp({24'h0, pulses}, 32'h0000_0001);
    axr(OFF_RAW, 32'h0000_0001);
    close_out();
  end
endmodule
`default_nettype wire
